// ==== watchdog_pkg.sv ====
// watchdog_pkg.sv: shared constants and types of the watchdog timer block
package watchdog_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;                    // byte address width
   localparam int DATA_W = 32;                   // avalon data width
   localparam int BE_W   = 4;                    // byte enables

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_WD_CTRL  = 5'h00; // watchdog_control
   localparam logic [ADDR_W-1:0] OFS_CK_CTRL  = 5'h04; // clock_control_reg
   localparam logic [ADDR_W-1:0] OFS_TA_KEY   = 5'h08; // timed-access key
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h0c; // sticky events
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10; // event mask
   localparam logic [ADDR_W-1:0] OFS_EIE      = 5'h14; // extended_irq_enable_reg
   localparam logic [ADDR_W-1:0] OFS_GIE      = 5'h18; // global_irq_enable

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int WD_RESTART_BIT = 0;            // restart_strobe
   localparam int WD_RSTEN_BIT   = 1;            // reset_on_timeout_enable
   localparam int WD_CAUSE_BIT   = 2;            // reset_cause_flag
   localparam int WD_TIMEOUT_BIT = 3;            // timeout_flag
   localparam int CK_SEL_LO_BIT  = 6;            // interval_select_lo
   localparam int CK_SEL_HI_BIT  = 7;            // interval_select_hi
   localparam int CK_OTHER_W     = 6;            // plain bits below the select
   localparam int EIE_WD_BIT     = 4;            // watchdog irq enable
   localparam int GIE_BIT        = 0;            // global irq enable
   localparam int IRQ_TIMEOUT    = 0;            // event: time-out
   localparam int IRQ_WDRESET    = 1;            // event: watchdog reset
   localparam int IRQ_W          = 2;            // number of events

   // ----------------------------------------------------------------
   // reset values and keys
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_RESET   = 2'h0;    // shortest interval
   localparam logic [7:0] TA_KEY_1    = 8'haa;   // first unlock byte
   localparam logic [7:0] TA_KEY_2    = 8'h55;   // second unlock byte

   // ----------------------------------------------------------------
   // timing, in clocks of clk
   // ----------------------------------------------------------------
   localparam int CNT_W              = 26;       // divider width
   localparam int INTERVAL_SEL0      = 131072;   // 2^17
   localparam int INTERVAL_SEL1      = 1048576;  // 2^20
   localparam int INTERVAL_SEL2      = 8388608;  // 2^23
   localparam int INTERVAL_SEL3      = 67108864; // 2^26
   localparam int GRACE_CLKS         = 512;      // wait after time-out
   localparam int GRACE_W            = 9;
   localparam logic [GRACE_W-1:0] GRACE_LAST = GRACE_W'(GRACE_CLKS - 1);
   localparam int MACHINE_CYCLE_CLKS = 4;        // clocks per machine cycle
   localparam int RESET_MC           = 2;        // reset length, machine cycles
   localparam int RESET_HOLD_CLKS    = MACHINE_CYCLE_CLKS * RESET_MC;
   localparam int HOLD_W             = 4;
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CLKS - 1);

   // ----------------------------------------------------------------
   // carriers and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [BE_W-1:0]   byteenable;
      logic [DATA_W-1:0] writedata;
   } avmm_req_type;

   typedef struct packed {
      logic              waitrequest;
      logic [DATA_W-1:0] readdata;
   } avmm_rsp_type;

   typedef enum {WD_COUNTING, WD_GRACE, WD_RESETTING} wd_state_type;

endpackage

// ==== watchdog_timed_access.sv ====
// watchdog_timed_access.sv: two-key unlock gate for the protected watchdog bits
`timescale 1ns/100ps
`default_nettype none

module watchdog_timed_access
   import watchdog_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wrTaken,     // a bus write takes effect this cycle
   input  wire logic       wrIsKey,     // that write targets the key register
   input  wire logic [7:0] wrByte,      // low byte of the write data
   output logic            unlocked     // next write may change protected bits
);

   // ----------------------------------------------------------------
   // key sequencing
   // ----------------------------------------------------------------
   logic armed_r;                       // first key seen
   logic open_r;                        // both keys seen in order

   // first key arms; any other write in between disarms
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
      end else if (wrTaken) begin
         armed_r <= wrIsKey && (wrByte == TA_KEY_1);
      end
   end

   // window spans exactly the one write after the second key;
   // counted in writes, not clocks, so a slow master cannot miss it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         open_r <= 1'b0;
      end else if (wrTaken) begin
         open_r <= wrIsKey && armed_r && (wrByte == TA_KEY_2);
      end
   end

   assign unlocked = open_r;

endmodule

`default_nettype wire

// ==== watchdog_timer.sv ====
// watchdog_timer.sv: watchdog divider, grace window, reset pulse and register slave
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - count clocks, set timeout flag each interval
// - keep counting, flag again every interval
// - irq request needs flag, enable, global enable
// - interrupt and reset paths are independent
// - restart bit clears counter, self-clears
// - two select bits choose the interval
// - intervals 2^17, 2^20, 2^23, 2^26 clocks
// - reset 512 clocks after timeout unless restarted
// - reset lasts two machine cycles, sets cause
// - cause flag sticky; untouched while reset disabled
// - timeout flag cleared by software or reset
// - clearing reset enable keeps counter running
// - power-on disables; watchdog reset restarts counter
// - interval defaults to shortest after reset
// - protected bits need timed-access procedure
module watchdog_timer
   import watchdog_pkg::*;
#(
   parameter int INTERVAL_00 = INTERVAL_SEL0,   // clocks for select 00
   parameter int INTERVAL_01 = INTERVAL_SEL1,   // clocks for select 01
   parameter int INTERVAL_10 = INTERVAL_SEL2,   // clocks for select 10
   parameter int INTERVAL_11 = INTERVAL_SEL3    // clocks for select 11
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,             // power-on / power-fail reset
   input  wire avmm_req_type busReq,            // avalon request
   output avmm_rsp_type      busRsp,            // waitrequest and readdata
   output logic              irq,               // unmasked sticky event
   output logic              wdIrqReq,          // watchdog interrupt request
   output logic              sysReset           // watchdog system reset
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // address match, used by every decode
   function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
      regHit = (addr == ofs);
   endfunction

   // last count of the selected interval
   function automatic logic [CNT_W-1:0] intervalLast(input logic [1:0] sel);
      case (sel)
         2'h0:    intervalLast = CNT_W'(INTERVAL_00 - 1);
         2'h1:    intervalLast = CNT_W'(INTERVAL_01 - 1);
         2'h2:    intervalLast = CNT_W'(INTERVAL_10 - 1);
         default: intervalLast = CNT_W'(INTERVAL_11 - 1);
      endcase
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                ack_r;             // second cycle of an access
   logic [DATA_W-1:0]   readdata_r;        // captured read word
   logic                reqActive;         // read or write pending
   logic                wrTaken;           // write takes effect now
   logic                rdTaken;           // read completes now
   logic                lane0;             // low byte lane enabled
   logic [7:0]          wrByte;            // low write byte
   logic                unlocked;          // timed access open
   logic                ctrlWr;            // write to watchdog_control
   logic                ctrlProtWr;        // unlocked write to it
   logic                ckWr;              // write to clock_control_reg

   logic                restart_r;         // restart_strobe
   logic                rstEnable_r;       // reset_on_timeout_enable
   logic                causeFlag_r;       // reset_cause_flag
   logic                timeoutFlag_r;     // timeout_flag
   logic [1:0]          intervalSel_r;     // interval_select_hi/lo
   logic [CK_OTHER_W-1:0] ckOther_r;       // remaining clock control bits
   logic                wdIrqEnable_r;     // extended irq enable, watchdog bit
   logic                globalIrqEn_r;     // global_irq_enable
   logic [IRQ_W-1:0]    irqStatus_r;       // sticky events
   logic [IRQ_W-1:0]    irqMask_r;         // event mask
   logic                wdIrqReq_r;        // registered irq request

   wd_state_type        state_r;           // watchdog sequence
   wd_state_type        state_nxt;
   logic [CNT_W-1:0]    count_r;           // free-running divider
   logic [GRACE_W-1:0]  graceCnt_r;        // clocks since time-out
   logic [HOLD_W-1:0]   holdCnt_r;         // clocks of reset pulse
   logic                timeoutTick;       // interval elapsed this clock
   logic                graceEnd;          // last grace clock
   logic                resetFire;         // watchdog reset begins
   logic [IRQ_W-1:0]    events;            // event pulses

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, answer on the second
   // ----------------------------------------------------------------
   assign reqActive = busReq.read | busReq.write;
   assign wrTaken   = busReq.write & ack_r;
   assign rdTaken   = busReq.read & ack_r;
   assign lane0     = busReq.byteenable[0];
   assign wrByte    = busReq.writedata[7:0];
   assign ctrlWr    = wrTaken & lane0 & regHit(busReq.address, OFS_WD_CTRL);
   assign ctrlProtWr = ctrlWr & unlocked;
   assign ckWr      = wrTaken & lane0 & regHit(busReq.address, OFS_CK_CTRL);

   // waitrequest is held in the first cycle of every access
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= reqActive & ~ack_r;
      end
   end

   // read word captured in the wait cycle, stands in the answer cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readdata_r <= '0;
      end else if (busReq.read & ~ack_r) begin
         readdata_r <= '0;              // unmapped and reserved read zero
         if (regHit(busReq.address, OFS_WD_CTRL)) begin
            readdata_r[WD_RESTART_BIT] <= restart_r;
            readdata_r[WD_RSTEN_BIT]   <= rstEnable_r;
            readdata_r[WD_CAUSE_BIT]   <= causeFlag_r;
            readdata_r[WD_TIMEOUT_BIT] <= timeoutFlag_r;
         end else if (regHit(busReq.address, OFS_CK_CTRL)) begin
            readdata_r[CK_SEL_HI_BIT:CK_SEL_LO_BIT] <= intervalSel_r;
            readdata_r[CK_OTHER_W-1:0]              <= ckOther_r;
         end else if (regHit(busReq.address, OFS_TA_KEY)) begin
            readdata_r[0] <= unlocked;
         end else if (regHit(busReq.address, OFS_IRQ_STAT)) begin
            readdata_r[IRQ_W-1:0] <= irqStatus_r;
         end else if (regHit(busReq.address, OFS_IRQ_MASK)) begin
            readdata_r[IRQ_W-1:0] <= irqMask_r;
         end else if (regHit(busReq.address, OFS_EIE)) begin
            readdata_r[EIE_WD_BIT] <= wdIrqEnable_r;
         end else if (regHit(busReq.address, OFS_GIE)) begin
            readdata_r[GIE_BIT] <= globalIrqEn_r;
         end
      end
   end

   assign busRsp.waitrequest = reqActive & ~ack_r;
   assign busRsp.readdata    = readdata_r;

   // ----------------------------------------------------------------
   // timed-access gate
   // ----------------------------------------------------------------
   watchdog_timed_access u_timed_access (
      .clk      (clk),
      .rst_n    (rst_n),
      .wrTaken  (wrTaken),
      .wrIsKey  (regHit(busReq.address, OFS_TA_KEY)),
      .wrByte   (wrByte),
      .unlocked (unlocked)
   );

   // ----------------------------------------------------------------
   // divider and sequence
   // ----------------------------------------------------------------

   // interval end; compare with >= so a shorter select never strands the count
   assign timeoutTick = (state_r != WD_RESETTING) & ~restart_r
                        & (count_r >= intervalLast(intervalSel_r));
   assign graceEnd    = (state_r == WD_GRACE) & (graceCnt_r == GRACE_LAST);
   // reset only if still enabled and no restart arrived in the window
   assign resetFire   = graceEnd & rstEnable_r & ~restart_r;

   // free-running count, cleared by restart or the watchdog reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (restart_r || state_r == WD_RESETTING) begin
         count_r <= '0;
      end else if (timeoutTick) begin
         count_r <= '0;                 // wrap, next interval starts
      end else begin
         count_r <= CNT_W'(count_r + 1'b1);
      end
   end

   // next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         WD_COUNTING: begin
            if (timeoutTick) begin
               state_nxt = WD_GRACE;    // open the grace window
            end
         end
         WD_GRACE: begin
            if (restart_r) begin
               state_nxt = WD_COUNTING; // pending reset cancelled
            end else if (resetFire) begin
               state_nxt = WD_RESETTING;
            end else if (graceEnd) begin
               state_nxt = WD_COUNTING; // reset disabled: just timing
            end
         end
         WD_RESETTING: begin
            if (holdCnt_r == HOLD_LAST) begin
               state_nxt = WD_COUNTING;
            end
         end
         default: begin
            state_nxt = WD_COUNTING;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= WD_COUNTING;
      end else begin
         state_r <= state_nxt;
      end
   end

   // grace clocks, counted from the time-out
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         graceCnt_r <= '0;
      end else if (state_r != WD_GRACE) begin
         graceCnt_r <= '0;
      end else begin
         graceCnt_r <= GRACE_W'(graceCnt_r + 1'b1);
      end
   end

   // reset pulse length
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         holdCnt_r <= '0;
      end else if (state_r != WD_RESETTING) begin
         holdCnt_r <= '0;
      end else begin
         holdCnt_r <= HOLD_W'(holdCnt_r + 1'b1);
      end
   end

   // ----------------------------------------------------------------
   // watchdog control bits
   // ----------------------------------------------------------------

   // restart strobe: set by an unlocked write, cleared by hardware next clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         restart_r <= 1'b0;
      end else if (restart_r) begin
         restart_r <= 1'b0;
      end else if (ctrlProtWr) begin
         restart_r <= wrByte[WD_RESTART_BIT];
      end
   end

   // reset enable: power-on clears it, the watchdog reset keeps it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rstEnable_r <= 1'b0;
      end else if (ctrlProtWr) begin
         rstEnable_r <= wrByte[WD_RSTEN_BIT];
      end
   end

   // time-out flag: reset clears, tick beats a software clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timeoutFlag_r <= 1'b0;
      end else if (resetFire) begin
         timeoutFlag_r <= 1'b0;
      end else if (timeoutTick) begin
         timeoutFlag_r <= 1'b1;
      end else if (ctrlProtWr) begin
         timeoutFlag_r <= wrByte[WD_TIMEOUT_BIT];
      end
   end

   // reset cause: the firing reset sets it, a plain write to watchdog_control may set or clear it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         causeFlag_r <= 1'b0;
      end else if (resetFire) begin
         causeFlag_r <= 1'b1;
      end else if (ctrlWr) begin
         causeFlag_r <= wrByte[WD_CAUSE_BIT];
      end
   end

   // interval select, back to the shortest on any reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         intervalSel_r <= SEL_RESET;
      end else if (resetFire) begin
         intervalSel_r <= SEL_RESET;
      end else if (ckWr) begin
         intervalSel_r <= wrByte[CK_SEL_HI_BIT:CK_SEL_LO_BIT];
      end
   end

   // remaining clock control bits are plain storage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ckOther_r <= '0;
      end else if (ckWr) begin
         ckOther_r <= wrByte[CK_OTHER_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // interrupt enables and request
   // ----------------------------------------------------------------

   // watchdog enable in the extended enable register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wdIrqEnable_r <= 1'b0;
      end else if (wrTaken && lane0 && regHit(busReq.address, OFS_EIE)) begin
         wdIrqEnable_r <= wrByte[EIE_WD_BIT];
      end
   end

   // global enable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         globalIrqEn_r <= 1'b0;
      end else if (wrTaken && lane0 && regHit(busReq.address, OFS_GIE)) begin
         globalIrqEn_r <= wrByte[GIE_BIT];
      end
   end

   // request needs all three; no term of the reset path enters it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wdIrqReq_r <= 1'b0;
      end else begin
         wdIrqReq_r <= timeoutFlag_r & wdIrqEnable_r & globalIrqEn_r;
      end
   end

   assign wdIrqReq = wdIrqReq_r;
   assign sysReset = (state_r == WD_RESETTING); // decoded from state flop

   // ----------------------------------------------------------------
   // sticky event status, cleared by reading it
   // ----------------------------------------------------------------
   assign events[IRQ_TIMEOUT] = timeoutTick;
   assign events[IRQ_WDRESET] = resetFire;

   // a new event in the clearing read's cycle survives
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqStatus_r <= '0;
      end else if (rdTaken && regHit(busReq.address, OFS_IRQ_STAT)) begin
         irqStatus_r <= events;
      end else begin
         irqStatus_r <= irqStatus_r | events;
      end
   end

   // mask of the same layout
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqMask_r <= '0;
      end else if (wrTaken && lane0 && regHit(busReq.address, OFS_IRQ_MASK)) begin
         irqMask_r <= wrByte[IRQ_W-1:0];
      end
   end

   assign irq = |(irqStatus_r & irqMask_r);

endmodule

`default_nettype wire

// ==== watchdog_timer_checker.sv ====
// watchdog_timer_checker.sv: port-level assertions for the watchdog timer
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_checker
   import watchdog_pkg::*;
#(
   parameter int INTERVAL_00 = INTERVAL_SEL0    // shortest interval in use
)
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire avmm_req_type busReq,
   input wire avmm_rsp_type busRsp,
   input wire logic         irq,
   input wire logic         wdIrqReq,
   input wire logic         sysReset
);
   // ---------------------------------------------
   // clocks since reset or the last watchdog reset
   // ---------------------------------------------
   int gap_r;   // saturates so it never wraps on long runs
   always_ff @(posedge clk) begin
      if (!rst_n || sysReset) gap_r <= 0;
      else if (gap_r < INTERVAL_00 + GRACE_CLKS) gap_r <= gap_r + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wait_first_a: assert property ($rose(busReq.read || busReq.write) |-> busRsp.waitrequest ##1 !busRsp.waitrequest) else $error("first access cycle not stalled");
   one_wait_a: assert property (busRsp.waitrequest |=> !busRsp.waitrequest) else $error("more than one wait cycle");
   idle_nowait_a: assert property (!(busReq.read || busReq.write) |-> !busRsp.waitrequest) else $error("waitrequest without request");
   read_width_a: assert property (busReq.read && !busRsp.waitrequest |-> busRsp.readdata[31:8] == 24'h0) else $error("upper read bits not zero");
   reset_len_a: assert property ($rose(sysReset) |-> sysReset[*8] ##1 !sysReset) else $error("watchdog reset length wrong");
   reset_gap_a: assert property ($rose(sysReset) |-> gap_r >= INTERVAL_00 + GRACE_CLKS - 4) else $error("watchdog reset too early");
   flag_drop_a: assert property ($rose(sysReset) |-> ##[1:3] !wdIrqReq) else $error("request kept over reset");
   release_quiet_a: assert property ($rose(rst_n) |-> !irq && !sysReset && !wdIrqReq) else $error("outputs active after reset");
endmodule
bind watchdog_timer watchdog_timer_checker #(.INTERVAL_00(INTERVAL_00)) checkerInst (.clk(clk),
   .rst_n(rst_n), .busReq(busReq), .busRsp(busRsp), .irq(irq), .wdIrqReq(wdIrqReq),
   .sysReset(sysReset));
`default_nettype wire

// ==== tb_watchdog_timer.sv ====
// tb_watchdog_timer.sv: self-checking bench for the watchdog timer
`timescale 1ns/100ps
`default_nettype none
module tb_watchdog_timer
   import watchdog_pkg::*;
;
   localparam int IV[4] = '{1024, 2048, 4096, 8192};   // shortened intervals
   logic         clk = 1'h0;
   logic         rst_n = 1'h0;
   avmm_req_type req = '0;
   avmm_rsp_type rsp;
   logic         irq, wdIrqReq, sysReset;
   int           rstClks = 0, rstMark = 0;            // watchdog reset clocks seen, mark
   logic [31:0]  q;                                   // last read data
   int           nErrors = 0, checksDone = 0, cyc = 0, n;
   always #20 clk = ~clk;
   watchdog_timer #(.INTERVAL_00(IV[0]), .INTERVAL_01(IV[1]), .INTERVAL_10(IV[2]),
      .INTERVAL_11(IV[3])) dut (.clk(clk), .rst_n(rst_n), .busReq(req), .busRsp(rsp),
      .irq(irq), .wdIrqReq(wdIrqReq), .sysReset(sysReset));
   // hang guard: well above the ~27000 clocks the tests need
   always @(posedge clk) begin
      cyc++;
      if (sysReset === 1'h1) rstClks <= rstClks + 1;
      if (cyc == 40000) begin
         nErrors++;
         wrapUp();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         nErrors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one bus access; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: {24'h0, d}};
      // no wait count assumed; only the hang guard ends a stuck access
      do begin
         @(posedge clk);
      end while (rsp.waitrequest !== 1'h0);
      q = rsp.readdata;
      req.read <= 1'h0;
      req.write <= 1'h0;
   endtask
   task automatic pwr(input logic [7:0] d);   // unlock, then protected write
      bus(1'h1, OFS_TA_KEY, TA_KEY_1);
      bus(1'h1, OFS_TA_KEY, TA_KEY_2);
      bus(1'h1, OFS_WD_CTRL, d);
   endtask
   // clocks until irq is seen high; looks only after an edge, since a
   // clearing read that just ended has not yet dropped irq at this instant
   task automatic waitIrq();
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (irq !== 1'h1 && n < 20000);
   endtask
   task automatic tRegs();
      bus(1'h0, OFS_WD_CTRL, 8'h00);
      chk(q, 32'h0);
      bus(1'h0, OFS_CK_CTRL, 8'h00);
      chk(q, 32'h0);
      bus(1'h1, OFS_WD_CTRL, 8'h0a);
      bus(1'h0, OFS_WD_CTRL, 8'h00);
      chk(q, 32'h0);
      bus(1'h1, 5'h1c, 8'hff);
      bus(1'h0, 5'h1c, 8'h00);
      chk(q, 32'h0);
      $display("register test done");
   endtask
   task automatic tReset();
      bus(1'h1, OFS_IRQ_MASK, 8'h03);
      bus(1'h1, OFS_EIE, 8'h10);
      bus(1'h1, OFS_GIE, 8'h01);
      pwr(8'h03);
      bus(1'h0, OFS_WD_CTRL, 8'h00);
      chk(q, 32'h2);
      waitIrq();
      chk(n inside {[IV[0]-6:IV[0]+2]}, 32'h1);
      @(posedge clk);
      #1;
      chk(wdIrqReq, 32'h1);
      n = 0;
      while (sysReset !== 1'h1 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n inside {[506:514]}, 32'h1);
      repeat (10) @(posedge clk);
      bus(1'h0, OFS_WD_CTRL, 8'h00);
      chk(q, 32'h6);
      bus(1'h0, OFS_IRQ_STAT, 8'h00);
      chk(q, 32'h3);
      bus(1'h0, OFS_IRQ_STAT, 8'h00);
      chk(q, 32'h0);
      $display("reset test done");
   endtask
   task automatic tGrace();
      waitIrq();
      pwr(8'h03);
      rstMark = rstClks;
      repeat (700) @(posedge clk);
      chk(rstClks - rstMark, 32'h0);
      bus(1'h0, OFS_IRQ_STAT, 8'h00);
      chk(q, 32'h1);
      $display("grace test done");
   endtask
   task automatic tSel();
      pwr(8'h01);
      bus(1'h0, OFS_WD_CTRL, 8'h00);
      chk(q, 32'h0);
      rstMark = rstClks;
      for (int s = 0; s < 4; s++) begin
         bus(1'h1, OFS_CK_CTRL, {s[1:0], 6'h00});
         bus(1'h0, OFS_IRQ_STAT, 8'h00);
         pwr(8'h01);
         waitIrq();
         chk(n inside {[IV[s]-2:IV[s]+2]}, 32'h1);
      end
      bus(1'h0, OFS_IRQ_STAT, 8'h00);
      waitIrq();
      chk(n inside {[IV[3]-6:IV[3]+1]}, 32'h1);
      chk(rstClks - rstMark, 32'h0);
      bus(1'h1, OFS_GIE, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk(wdIrqReq, 32'h0);
      chk(irq, 32'h1);
      bus(1'h0, OFS_CK_CTRL, 8'h00);
      chk(q, 32'hc0);
      $display("interval test done");
   endtask
   task automatic wrapUp();
      $display("checks %0d errors %0d", checksDone, nErrors);
      if (nErrors == 0 && checksDone > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      tRegs();
      tReset();
      tGrace();
      tSel();
      wrapUp();
   end
endmodule
`default_nettype wire
